// >>> verilog/nss_pkg.sv
package nss_pkg;
	// system clock and timing
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	localparam int SELFTEST_MS = 250;
	localparam int RUN_MIN_MS = 2;
	localparam logic [2:0] RUN_CODE_MAX = 3'h6;
	// register map
	localparam logic [6:0] ADDR_PEAK = 7'h09;
	localparam logic [6:0] ADDR_TOTAL = 7'h0a;
	localparam logic [6:0] ADDR_FLOOR = 7'h0b;
	localparam logic [6:0] ADDR_SIG0 = 7'h0c;
	localparam logic [6:0] ADDR_SIG1 = 7'h0d;
	localparam logic [6:0] ADDR_SIG2 = 7'h0e;
	localparam logic [6:0] ADDR_SIG3 = 7'h0f;
	localparam logic [6:0] ADDR_TRIG = 7'h10;
	localparam logic [6:0] ADDR_SETUP = 7'h12;
	// reset values
	localparam logic [7:0] RST_PEAK = 8'hd0;
	localparam logic [7:0] RST_TOTAL = 8'h80;
	localparam logic [7:0] RST_FLOOR = 8'h00;
	localparam logic [7:0] RST_SIG = 8'h00;
	localparam logic [7:0] RST_SETUP = 8'h26;
	localparam logic [7:0] RD_NONE = 8'h00;
	// self-test result bytes
	localparam logic [7:0] SIG0_VAL = 8'h18;
	localparam logic [7:0] SIG1_VAL = 8'h44;
	localparam logic [7:0] SIG2_VAL = 8'h62;
	localparam logic [7:0] SIG3_VAL = 8'h47;
	// pixel statistics
	localparam logic [7:0] PIX_LIMIT = 8'hfe;
	localparam logic [7:0] TOTAL_LIMIT = 8'ha7;
	localparam int SUM_W = 18;
	localparam int SUM_LSB = 10;
	localparam logic [SUM_W-1:0] SUM_ZERO = 18'h00000;
	localparam logic [7:0] PIX_FLOOR_INIT = 8'hff;
	localparam logic [7:0] PIX_PEAK_INIT = 8'h00;
	// setup fields
	localparam logic [7:0] SETUP_WMASK = 8'h7f;
	localparam int SETUP_CPI_HI = 6;
	localparam int SETUP_CPI_LO = 5;
	localparam int SETUP_AWAKE = 3;
	localparam int SETUP_RATE_HI = 2;
	localparam int TRIG_GO = 0;
	localparam logic [10:0] CPI_400 = 11'h190;
	localparam logic [10:0] CPI_800 = 11'h320;
	localparam logic [10:0] CPI_1200 = 11'h4b0;
	localparam logic [10:0] CPI_1600 = 11'h640;
	// serial port framing
	localparam int CMD_WR = 7;
	localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
	localparam logic [4:0] BIT_DATA_FIRST = 5'h08;
	localparam logic [4:0] BIT_DATA_LAST = 5'h0f;
	localparam logic [4:0] BIT_END = 5'h10;

	typedef enum logic [1:0]
	{
		NSS_ST_IDLE = 2'b00,
		NSS_ST_RUN = 2'b01,
		NSS_ST_DONE = 2'b10
	} nss_selftest_e;
endpackage : nss_pkg

// >>> verilog/nss_frame_stats.sv
`timescale 1ns/1ps
module nss_frame_stats
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic pix_valid_i,
	input wire logic [7:0] pix_data_i,
	input wire logic pix_last_i,
	output logic [7:0] peak_o,
	output logic [7:0] floor_o,
	output logic [7:0] total_o,
	output logic upd_o
);
	logic [nss_pkg::SUM_W-1:0] sum_ff;
	logic [7:0] max_ff;
	logic [7:0] min_ff;
	logic [nss_pkg::SUM_W-1:0] nxt_sum;
	logic [7:0] nxt_max;
	logic [7:0] nxt_min;
	logic [7:0] sum_hi;
	logic frame_end;

	assign frame_end = pix_valid_i & pix_last_i;
	assign nxt_sum = sum_ff + {{(nss_pkg::SUM_W-8){1'b0}}, pix_data_i};
	assign nxt_max = (pix_data_i > max_ff) ? pix_data_i : max_ff;
	assign nxt_min = (pix_data_i < min_ff) ? pix_data_i : min_ff;
	assign sum_hi = nxt_sum[nss_pkg::SUM_W-1:nss_pkg::SUM_LSB];

	// running accumulators restart after the last pixel of each frame
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || frame_end)
		begin
			sum_ff <= nss_pkg::SUM_ZERO;
			max_ff <= nss_pkg::PIX_PEAK_INIT;
			min_ff <= nss_pkg::PIX_FLOOR_INIT;
		end
		else if (pix_valid_i)
		begin
			sum_ff <= nxt_sum;
			max_ff <= nxt_max;
			min_ff <= nxt_min;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			peak_o <= nss_pkg::RST_PEAK;
			floor_o <= nss_pkg::RST_FLOOR;
			total_o <= nss_pkg::RST_TOTAL;
			upd_o <= 1'b0;
		end
		else
		begin
			upd_o <= frame_end;
			if (frame_end)
			begin
				peak_o <= (nxt_max > nss_pkg::PIX_LIMIT) ? nss_pkg::PIX_LIMIT : nxt_max;
				floor_o <= (nxt_min > nss_pkg::PIX_LIMIT) ? nss_pkg::PIX_LIMIT : nxt_min;
				total_o <= (sum_hi > nss_pkg::TOTAL_LIMIT) ? nss_pkg::TOTAL_LIMIT : sum_hi;
			end
		end
	end
endmodule : nss_frame_stats

// >>> verilog/nss_stats_regs.sv
// Function
// - peak register holds largest pixel of last frame, capped at 254, resets 0xd0
// - 18-bit pixel sum kept per frame; register shows sum divided by 1024
// - intensity total stays within 0..167, may change each frame, resets 0x80
// - floor register holds smallest pixel of last frame, capped at 254, resets zero
// - after self-test, signature bytes 0 and 1 read 0x18 and 0x44
// - after self-test, signature bytes 2 and 3 read 0x62 and 0x47
// - writing bit 0 set to address 0x10 starts self-test; zero does nothing
// - self-test runs 250ms then loads the four signature registers
// - setup bits 6:5 pick 400, 800, 1200 or 1600 counts per inch
// - setup bit 3 set forces awake; clear allows rest modes
// - setup bits 2:0 set frame period 2ms to 8ms in 1ms steps
// - setup register resets to 0x26 and bit 7 always reads zero
`timescale 1ns/1ps
module nss_stats_regs
#(
	parameter int MS_CYCLES = nss_pkg::CLK_HZ / nss_pkg::MS_PER_S,
	parameter int ST_CYCLES = nss_pkg::SELFTEST_MS * (nss_pkg::CLK_HZ / nss_pkg::MS_PER_S)
)
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	input wire logic pix_valid_i,
	input wire logic [7:0] pix_data_i,
	input wire logic pix_last_i,
	output logic frame_start_o,
	output logic [10:0] cpi_count_o,
	output logic force_awake_o,
	output logic selftest_busy_o
);
	logic [1:0] cs_sq_ff;
	logic [2:0] sclk_sq_ff;
	logic [1:0] mosi_sq_ff;
	logic [4:0] bit_cnt_ff;
	logic [7:0] rx_sh_ff;
	logic [7:0] cmd_ff;
	logic [7:0] tx_sh_ff;
	logic [7:0] setup_ff;
	logic [7:0] sig_ff [4];
	logic [23:0] st_cnt_ff;
	logic [19:0] frame_cnt_ff;
	nss_pkg::nss_selftest_e st_ff;
	nss_pkg::nss_selftest_e nxt_st;
	logic [7:0] peak_w;
	logic [7:0] floor_w;
	logic [7:0] total_w;
	logic stats_upd_w;

	logic cs_act;
	logic sclk_rise;
	logic sclk_fall;
	logic mosi_s;
	logic [7:0] rx_byte;
	logic addr_done;
	logic data_done;
	logic wr_en;
	logic [6:0] wr_addr;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic st_go;
	logic st_end;
	logic [2:0] run_code;
	logic [3:0] run_ms;
	logic [19:0] period_m1;
	logic frame_wrap;
	logic [10:0] cpi_sel;
	logic [7:0] sig_val [4];

	assign sig_val[0] = nss_pkg::SIG0_VAL;
	assign sig_val[1] = nss_pkg::SIG1_VAL;
	assign sig_val[2] = nss_pkg::SIG2_VAL;
	assign sig_val[3] = nss_pkg::SIG3_VAL;

	// pins are two-flop synchronised; only stage 1 and later feed logic
	always_ff @(posedge clk_i)
	begin
		cs_sq_ff <= {cs_sq_ff[0], spi_cs_n_i};
		sclk_sq_ff <= {sclk_sq_ff[1:0], spi_sclk_i};
		mosi_sq_ff <= {mosi_sq_ff[0], spi_mosi_i};
	end

	assign cs_act = ~cs_sq_ff[1];
	assign sclk_rise = cs_act & sclk_sq_ff[1] & ~sclk_sq_ff[2];
	assign sclk_fall = cs_act & ~sclk_sq_ff[1] & sclk_sq_ff[2];
	assign mosi_s = mosi_sq_ff[1];
	assign rx_byte = {rx_sh_ff[6:0], mosi_s};
	assign addr_done = sclk_rise & (bit_cnt_ff == nss_pkg::BIT_ADDR_LAST);
	assign data_done = sclk_rise & (bit_cnt_ff == nss_pkg::BIT_DATA_LAST) & cmd_ff[nss_pkg::CMD_WR];
	// the host keeps the port quiet during self-test; a write then is dropped
	assign wr_en = data_done & (st_ff != nss_pkg::NSS_ST_RUN);
	assign wr_addr = cmd_ff[6:0];
	assign rd_addr = rx_byte[6:0];

	assign rd_data = (rd_addr == nss_pkg::ADDR_PEAK) ? peak_w :
		(rd_addr == nss_pkg::ADDR_TOTAL) ? total_w :
		(rd_addr == nss_pkg::ADDR_FLOOR) ? floor_w :
		(rd_addr == nss_pkg::ADDR_SIG0) ? sig_ff[0] :
		(rd_addr == nss_pkg::ADDR_SIG1) ? sig_ff[1] :
		(rd_addr == nss_pkg::ADDR_SIG2) ? sig_ff[2] :
		(rd_addr == nss_pkg::ADDR_SIG3) ? sig_ff[3] :
		(rd_addr == nss_pkg::ADDR_SETUP) ? setup_ff : nss_pkg::RD_NONE;

	// serial framing: address byte, then one data byte, msb first
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || !cs_act)
			bit_cnt_ff <= 5'h00;
		else if (sclk_rise && bit_cnt_ff != nss_pkg::BIT_END)
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			rx_sh_ff <= 8'h00;
			cmd_ff <= 8'h00;
		end
		else
		begin
			if (sclk_rise)
				rx_sh_ff <= rx_byte;
			if (addr_done)
				cmd_ff <= rx_byte;
		end
	end

	// read data leaves on falling edges so the host samples it on rising ones
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			tx_sh_ff <= 8'h00;
			spi_miso_o <= 1'b0;
			spi_miso_oe_o <= 1'b0;
		end
		else
		begin
			spi_miso_oe_o <= cs_act;
			if (addr_done)
				tx_sh_ff <= rx_byte[nss_pkg::CMD_WR] ? nss_pkg::RD_NONE : rd_data;
			else if (sclk_fall && bit_cnt_ff >= nss_pkg::BIT_DATA_FIRST && bit_cnt_ff != nss_pkg::BIT_END)
			begin
				spi_miso_o <= tx_sh_ff[7];
				tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			setup_ff <= nss_pkg::RST_SETUP;
		else if (wr_en && wr_addr == nss_pkg::ADDR_SETUP)
			setup_ff <= rx_byte & nss_pkg::SETUP_WMASK;
	end

	// self-test sequencer
	assign st_go = wr_en & (wr_addr == nss_pkg::ADDR_TRIG) & rx_byte[nss_pkg::TRIG_GO];
	assign st_end = (st_ff == nss_pkg::NSS_ST_RUN) && (st_cnt_ff == 24'(ST_CYCLES - 1));

	always_comb
	begin
		nxt_st = st_ff;
		unique case (st_ff)
			nss_pkg::NSS_ST_IDLE: if (st_go) nxt_st = nss_pkg::NSS_ST_RUN;
			nss_pkg::NSS_ST_RUN: if (st_end) nxt_st = nss_pkg::NSS_ST_DONE;
			nss_pkg::NSS_ST_DONE: if (st_go) nxt_st = nss_pkg::NSS_ST_RUN;
			default: nxt_st = nss_pkg::NSS_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			st_ff <= nss_pkg::NSS_ST_IDLE;
			st_cnt_ff <= 24'h000000;
			selftest_busy_o <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			selftest_busy_o <= (nxt_st == nss_pkg::NSS_ST_RUN);
			st_cnt_ff <= (st_ff == nss_pkg::NSS_ST_RUN) ? st_cnt_ff + 24'h000001 : 24'h000000;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sig
			always_ff @(posedge clk_i)
			begin
				if (sys_rst_i)
					sig_ff[gi] <= nss_pkg::RST_SIG;
				else if (st_end)
					sig_ff[gi] <= sig_val[gi];
			end
		end
	endgenerate

	// run frame timer; code 111 is clamped to the longest period
	assign run_code = setup_ff[nss_pkg::SETUP_RATE_HI:0];
	assign run_ms = 4'(nss_pkg::RUN_MIN_MS) + {1'b0, (run_code > nss_pkg::RUN_CODE_MAX) ? nss_pkg::RUN_CODE_MAX : run_code};
	assign period_m1 = 20'(int'(run_ms) * MS_CYCLES - 1);
	assign frame_wrap = (frame_cnt_ff >= period_m1);

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			frame_cnt_ff <= 20'h00000;
			frame_start_o <= 1'b0;
		end
		else
		begin
			frame_cnt_ff <= frame_wrap ? 20'h00000 : frame_cnt_ff + 20'h00001;
			frame_start_o <= frame_wrap;
		end
	end

	assign cpi_sel = (setup_ff[nss_pkg::SETUP_CPI_HI:nss_pkg::SETUP_CPI_LO] == 2'h0) ? nss_pkg::CPI_400 :
		(setup_ff[nss_pkg::SETUP_CPI_HI:nss_pkg::SETUP_CPI_LO] == 2'h1) ? nss_pkg::CPI_800 :
		(setup_ff[nss_pkg::SETUP_CPI_HI:nss_pkg::SETUP_CPI_LO] == 2'h2) ? nss_pkg::CPI_1200 : nss_pkg::CPI_1600;

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			// must agree with the resolution code held in the setup reset value
			cpi_count_o <= nss_pkg::CPI_800;
			force_awake_o <= 1'b0;
		end
		else
		begin
			cpi_count_o <= cpi_sel;
			force_awake_o <= setup_ff[nss_pkg::SETUP_AWAKE];
		end
	end

	nss_frame_stats u_stats
	(
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pix_valid_i(pix_valid_i),
		.pix_data_i(pix_data_i),
		.pix_last_i(pix_last_i),
		.peak_o(peak_w),
		.floor_o(floor_w),
		.total_o(total_w),
		.upd_o(stats_upd_w)
	);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_frame_done;
		pix_valid_i && pix_last_i;
	endsequence

	sequence s_st_finish;
		st_end ##1 1'b1;
	endsequence

	property p_peak_limit;
		s_frame_done |=> (peak_w <= nss_pkg::PIX_LIMIT) && stats_upd_w;
	endproperty
	a_peak_limit: assert property (p_peak_limit) else $error("peak level above limit");

	property p_floor_limit;
		s_frame_done |=> (floor_w <= nss_pkg::PIX_LIMIT) && (floor_w <= peak_w);
	endproperty
	a_floor_limit: assert property (p_floor_limit) else $error("floor level wrong");

	property p_total_limit;
		total_w <= nss_pkg::TOTAL_LIMIT || total_w == nss_pkg::RST_TOTAL;
	endproperty
	a_total_limit: assert property (p_total_limit) else $error("intensity total above limit");

	property p_total_hold;
		!stats_upd_w ##1 !stats_upd_w |-> $stable(total_w);
	endproperty
	a_total_hold: assert property (p_total_hold) else $error("intensity total changed mid-frame");

	property p_sig_low;
		s_st_finish |-> sig_ff[0] == nss_pkg::SIG0_VAL && sig_ff[1] == nss_pkg::SIG1_VAL;
	endproperty
	a_sig_low: assert property (p_sig_low) else $error("signature bytes 0-1 wrong");

	property p_sig_high;
		s_st_finish |-> sig_ff[2] == nss_pkg::SIG2_VAL && sig_ff[3] == nss_pkg::SIG3_VAL;
	endproperty
	a_sig_high: assert property (p_sig_high) else $error("signature bytes 2-3 wrong");

	property p_st_start;
		st_go && st_ff != nss_pkg::NSS_ST_RUN |=> selftest_busy_o && st_cnt_ff == 24'h000000;
	endproperty
	a_st_start: assert property (p_st_start) else $error("self-test did not start");

	property p_st_length;
		$fell(selftest_busy_o) |-> $past(st_cnt_ff) == 24'(ST_CYCLES - 1);
	endproperty
	a_st_length: assert property (p_st_length) else $error("self-test length wrong");

	property p_cpi;
		##1 cpi_count_o == $past(cpi_sel) && cpi_count_o != 11'h000;
	endproperty
	a_cpi: assert property (p_cpi) else $error("resolution output wrong");

	property p_awake;
		##1 force_awake_o == $past(setup_ff[nss_pkg::SETUP_AWAKE]);
	endproperty
	a_awake: assert property (p_awake) else $error("awake output wrong");

	property p_frame_period;
		frame_start_o && $past(period_m1) == $past(period_m1, 2) |->
			$past(frame_cnt_ff) == 20'(int'($past(run_ms)) * MS_CYCLES - 1) && $past(run_ms) <= 4'h8;
	endproperty
	a_frame_period: assert property (p_frame_period) else $error("frame period wrong");

	property p_setup_bit7;
		!setup_ff[7];
	endproperty
	a_setup_bit7: assert property (p_setup_bit7) else $error("setup bit 7 set");
endmodule : nss_stats_regs

// >>> test/nss_host_model.sv
`timescale 1ns/1ps
module nss_host_model
#(
	parameter int HALF = 6
)
(
	input wire logic clk_i,
	input wire logic miso_i,
	input wire logic miso_oe_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic mosi_o
);
	logic last_ff = 1'b0;
	// a released data line shows the inverse of its last driven level
	wire logic line = miso_oe_i ? miso_i : ~last_ff;
	always @(posedge clk_i)
	begin
		if (miso_oe_i)
			last_ff <= miso_i;
	end
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end
	// address byte then data byte, msb first, sampled just before each rise
	task automatic xfer(input logic [15:0] w, output logic [7:0] q);
		q = 8'h00;
		@(negedge clk_i);
		cs_n_o = 1'b0;
		repeat (HALF) @(negedge clk_i);
		for (int i = 15; i >= 0; i--)
		begin
			mosi_o = w[i];
			repeat (HALF) @(negedge clk_i);
			q = {q[6:0], line};
			sclk_o = 1'b1;
			repeat (HALF) @(negedge clk_i);
			sclk_o = 1'b0;
		end
		repeat (HALF) @(negedge clk_i);
		cs_n_o = 1'b1;
		repeat (HALF) @(negedge clk_i);
	endtask : xfer
endmodule : nss_host_model

// >>> test/nav_sensor_stats_selftest_config_tb_top.sv
`timescale 1ns/1ps
module nav_sensor_stats_selftest_config_tb_top;
	localparam int MS = 20;
	localparam int ST = 100;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic pix_valid_i = 1'b0;
	logic [7:0] pix_data_i = 8'h00;
	logic pix_last_i = 1'b0;
	wire logic cs_n, sclk, mosi, miso, miso_oe, frame_start, force_awake, busy;
	wire logic [10:0] cpi_count;
	int n_errors = 0;
	int total_checks = 0;
	int busy_cycles = 0;
	logic [31:0] seed = 32'h7414e3d4;
	logic [7:0] rd;
	logic [6:0] rst_addr [10] = '{7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h12, 7'h11, 7'h10};
	logic [7:0] rst_val [10] = '{8'hd0, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h26, 8'h00, 8'h00};
	logic [7:0] sig_val [4] = '{8'h18, 8'h44, 8'h62, 8'h47};

	always #10 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		if (busy === 1'b1)
			busy_cycles++;
	end

	nss_stats_regs #(.MS_CYCLES(MS), .ST_CYCLES(ST)) DUT
	(
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.spi_cs_n_i(cs_n),
		.spi_sclk_i(sclk),
		.spi_mosi_i(mosi),
		.spi_miso_o(miso),
		.spi_miso_oe_o(miso_oe),
		.pix_valid_i(pix_valid_i),
		.pix_data_i(pix_data_i),
		.pix_last_i(pix_last_i),
		.frame_start_o(frame_start),
		.cpi_count_o(cpi_count),
		.force_awake_o(force_awake),
		.selftest_busy_o(busy)
	);
	nss_host_model HOST
	(
		.clk_i(clk_i),
		.miso_i(miso),
		.miso_oe_i(miso_oe),
		.cs_n_o(cs_n),
		.sclk_o(sclk),
		.mosi_o(mosi)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] cap(input logic [7:0] v);
		return (v > 8'hfe) ? 8'hfe : v;
	endfunction : cap
	function automatic logic [7:0] tot(input int s);
		return ((s >> 10) > 167) ? 8'ha7 : 8'(s >> 10);
	endfunction : tot
	function automatic logic [10:0] cpi(input logic [1:0] c);
		return 11'(400 * (int'(c) + 1));
	endfunction : cpi
	function automatic int period(input logic [2:0] c);
		return (2 + ((c > 3'h6) ? 6 : int'(c))) * MS;
	endfunction : period

	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val
	task automatic chk_cnt(input string what, input int exp, input int got);
		total_checks++;
		if (got != exp)
		begin
			n_errors++;
			$display("BAD %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_cnt
	task automatic rd_reg(input logic [6:0] a, output logic [7:0] q);
		HOST.xfer({1'b0, a, 8'h00}, q);
	endtask : rd_reg
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		HOST.xfer({1'b1, a, d}, q);
	endtask : wr_reg
	task automatic do_reset();
		@(negedge clk_i);
		sys_rst_i = 1'b1;
		repeat (8) @(negedge clk_i);
		sys_rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
	endtask : do_reset
	task automatic gap(output int n);
		n = 0;
		do
		begin
			@(negedge clk_i);
			n++;
		end
		while (frame_start !== 1'b1 && n < 1000);
	endtask : gap
	task automatic send_frame(input int n, input bit full);
		int s;
		logic [7:0] mx, mn, p;
		s = 0;
		mx = 8'h00;
		mn = 8'hff;
		for (int i = 0; i < n; i++)
		begin
			seed = lfsr(seed);
			p = full ? 8'hff : seed[7:0];
			@(negedge clk_i);
			pix_valid_i = 1'b1;
			pix_data_i = p;
			pix_last_i = (i == n - 1);
			s += p;
			mx = (p > mx) ? p : mx;
			mn = (p < mn) ? p : mn;
		end
		@(negedge clk_i);
		pix_valid_i = 1'b0;
		pix_last_i = 1'b0;
		repeat (3) @(negedge clk_i);
		rd_reg(nss_pkg::ADDR_PEAK, rd);
		chk_val("peak", cap(mx), rd);
		rd_reg(nss_pkg::ADDR_TOTAL, rd);
		chk_val("total", tot(s), rd);
		rd_reg(nss_pkg::ADDR_FLOOR, rd);
		chk_val("floor", cap(mn), rd);
	endtask : send_frame
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	initial
	begin
		int n;
		logic [2:0] k;
		logic [7:0] v;
		do_reset();
		for (int i = 0; i < 10; i++)
		begin
			rd_reg(rst_addr[i], rd);
			chk_val("reset value", rst_val[i], rd);
		end
		chk_val("cpi after reset", cpi(rst_val[7][6:5]), cpi_count);
		$display("test reset_values done");
		for (int c = 0; c < 8; c++)
		begin
			k = c[2:0];
			seed = lfsr(seed);
			v = {1'b1, k[1:0], seed[1:0], k};
			wr_reg(nss_pkg::ADDR_SETUP, v);
			rd_reg(nss_pkg::ADDR_SETUP, rd);
			chk_val("setup", v & 8'h7f, rd);
			chk_val("cpi", cpi(k[1:0]), cpi_count);
			chk_val("awake", v[3], force_awake);
			gap(n);
			gap(n);
			gap(n);
			chk_cnt("frame period", period(k), n);
		end
		$display("test setup_codes done");
		send_frame(700, 1'b1);
		wr_reg(nss_pkg::ADDR_PEAK, 8'h11);
		rd_reg(nss_pkg::ADDR_PEAK, rd);
		chk_val("peak after write", 8'hfe, rd);
		repeat (3) send_frame(24, 1'b0);
		$display("test pixel_stats done");
		do_reset();
		wr_reg(nss_pkg::ADDR_TRIG, 8'hfe);
		repeat (5) @(negedge clk_i);
		chk_val("busy on zero", 1'b0, busy);
		busy_cycles = 0;
		wr_reg(nss_pkg::ADDR_TRIG, 8'h01);
		chk_val("busy", 1'b1, busy);
		// the serial port stays idle until the test finishes
		n = 0;
		while (busy !== 1'b0 && n < 1000)
		begin
			@(negedge clk_i);
			n++;
		end
		chk_cnt("selftest length", ST, busy_cycles);
		for (int i = 0; i < 4; i++)
		begin
			rd_reg(7'(7'h0c + i), rd);
			chk_val("signature", sig_val[i], rd);
		end
		do_reset();
		rd_reg(nss_pkg::ADDR_SIG3, rd);
		chk_val("signature after reset", 8'h00, rd);
		$display("test selftest done");
		give_verdict();
	end

	initial
	begin
		repeat (60000) @(posedge clk_i);
		n_errors++;
		give_verdict();
	end
endmodule : nav_sensor_stats_selftest_config_tb_top
